// file: verilog/adc_port_cfg.svh
// Constants for the converter byte output port
`ifndef ADC_PORT_CFG_SVH
`define ADC_PORT_CFG_SVH
`define RESULT_W 14
`define BYTE_W 8
`define HIGH_BYTE_W 6
`define POL_BIT 13
`define OVR_BIT 12
`define CLK_PERIOD_NS 5
`define INT_CLK_NS 40
`define HALF_DIV ((`INT_CLK_NS / 2) / `CLK_PERIOD_NS)
`define DIV_W 8
`define BUF_DEPTH 2
`endif

// file: verilog/adc_port_pkg.sv
// Types used by the converter end of the byte output port
`default_nettype none
package adc_port_pkg;
	typedef enum logic [2:0] {
		HS_IDLE,
		HS_WAIT_HI,
		HS_HI_LOAD,
		HS_HI_HOLD,
		HS_WAIT_LO,
		HS_LO_LOAD,
		HS_LO_HOLD,
		HS_DONE
	} hs_state_t;
	typedef logic [13:0] result_t;
endpackage
`default_nettype wire

// file: verilog/adc_port_if.sv
// Pin bundle between converter and receiver
`default_nettype none
interface adc_port_if;
	logic [7:0] data;
	logic [7:0] data_oe;
	logic load_n_dev;
	logic load_n_dev_oe;
	logic load_n_rx;
	logic high_byte_enable_dev;
	logic low_byte_enable_dev;
	logic byte_en_dev_oe;
	logic high_byte_enable_rx;
	logic low_byte_enable_rx;
	logic send;
	logic mode;
	logic run_hold;
	logic status;
	modport dev_mp (
		output data, data_oe, load_n_dev, load_n_dev_oe, high_byte_enable_dev, low_byte_enable_dev,
		output byte_en_dev_oe, status,
		input load_n_rx, high_byte_enable_rx, low_byte_enable_rx, send, mode, run_hold
	);
	modport rx_mp (
		input data, data_oe, load_n_dev, load_n_dev_oe, high_byte_enable_dev, low_byte_enable_dev,
		input byte_en_dev_oe, status,
		output load_n_rx, high_byte_enable_rx, low_byte_enable_rx, send, mode, run_hold
	);
endinterface
`default_nettype wire

// file: verilog/adc_port_rx.sv
// Receiver end: direct reads or handshake byte capture
`default_nettype none
`include "adc_port_cfg.svh"
module adc_port_rx (
	input wire logic clk_i,
	input wire logic reset_i,
	adc_port_if.rx_mp port,
	input wire logic mode_i,
	input wire logic run_i,
	input wire logic read_high_i,
	input wire logic read_low_i,
	input wire logic out_ready_i,
	output logic [7:0] byte_o,
	output logic byte_high_o,
	output logic byte_valid_o,
	output logic new_data_o
);
	logic [2:0] load_sync_reg;
	logic [2:0] stat_sync_reg;
	logic [7:0] d1_reg;
	logic [7:0] d2_reg;
	logic [1:0] h_sync_reg;
	logic full_reg;

	assign port.send = mode_i ? (!full_reg && load_sync_reg[1] && load_sync_reg[2]) : 1'b1;
	assign port.mode = mode_i;
	assign port.run_hold = run_i;
	assign port.load_n_rx = mode_i ? 1'b1 : !(read_high_i || read_low_i);
	assign port.high_byte_enable_rx = read_high_i;
	assign port.low_byte_enable_rx = read_low_i;

	always_ff @(posedge clk_i)
	begin
		load_sync_reg <= {load_sync_reg[1:0], port.load_n_dev};
		stat_sync_reg <= {stat_sync_reg[1:0], port.status};
		d1_reg <= port.data;
		d2_reg <= d1_reg;
		h_sync_reg <= {h_sync_reg[0], port.high_byte_enable_dev};
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			new_data_o <= 1'b0;
		else
			new_data_o <= stat_sync_reg[2] && !stat_sync_reg[1];
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			full_reg <= 1'b0;
			byte_o <= 8'h00;
			byte_high_o <= 1'b0;
		end
		else if (mode_i && !load_sync_reg[2] && load_sync_reg[1])
		begin
			full_reg <= 1'b1;
			byte_o <= d2_reg;
			byte_high_o <= !h_sync_reg[1];
		end
		else if (out_ready_i)
			full_reg <= 1'b0;
	end
	assign byte_valid_o = full_reg;
endmodule
`default_nettype wire

// file: verilog/adc_port_dev.sv
// Converter end: direct and handshake byte output
`default_nettype none
`include "adc_port_cfg.svh"
module adc_port_dev (
	input wire logic clk_i,
	input wire logic reset_i,
	adc_port_if.dev_mp port,
	input wire logic [13:0] result_i,
	input wire logic result_valid_i,
	output logic result_ready_o,
	output logic convert_o,
	output logic busy_o
);
	logic [`DIV_W-1:0] div_reg;
	logic half_tick, phase_reg, rise_tick, fall_tick;
	logic [1:0] send_sync_reg, mode_sync_reg, run_sync_reg, ce_sync_reg, hbe_sync_reg, lbe_sync_reg;
	logic mode_prev_reg, send_smp_reg, status_reg, hs_req_reg;
	adc_port_pkg::result_t buf_reg [0:`BUF_DEPTH-1];
	logic [1:0] buf_cnt_reg, hold_cnt_reg;
	logic buf_wr_ptr_reg, buf_rd_ptr_reg;
	adc_port_pkg::result_t out_reg;
	adc_port_pkg::hs_state_t state_reg;
	logic [7:0] data_reg, oe_reg;
	logic load_n_reg, hbe_reg, lbe_reg, hs_oe_reg;
	logic hs_active, buf_push, buf_pop, buf_latch;
	function automatic logic [7:0] high_byte(input adc_port_pkg::result_t r);
		high_byte = {2'h0, r[`POL_BIT], r[`OVR_BIT], r[11:8]};
	endfunction
	// Internal conversion clock as half-period enables
	always_ff @(posedge clk_i)
	begin
		if (reset_i || half_tick)
			div_reg <= '0;
		else
			div_reg <= div_reg + `DIV_W'(1);
	end
	assign half_tick = (div_reg == `DIV_W'(`HALF_DIV - 1));
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			phase_reg <= 1'b0;
		else if (half_tick)
			phase_reg <= !phase_reg;
	end
	assign rise_tick = half_tick && !phase_reg;
	assign fall_tick = half_tick && phase_reg;

	always_ff @(posedge clk_i)
	begin
		send_sync_reg <= {send_sync_reg[0], port.send};
		mode_sync_reg <= {mode_sync_reg[0], port.mode};
		run_sync_reg <= {run_sync_reg[0], port.run_hold};
		ce_sync_reg <= {ce_sync_reg[0], port.load_n_rx};
		hbe_sync_reg <= {hbe_sync_reg[0], port.high_byte_enable_rx};
		lbe_sync_reg <= {lbe_sync_reg[0], port.low_byte_enable_rx};
	end

	assign convert_o = run_sync_reg[1];
	// Two-entry result buffer, drained every cycle
	assign hs_active = (state_reg != adc_port_pkg::HS_IDLE) || hs_req_reg;
	assign result_ready_o = (buf_cnt_reg != 2'h2);
	assign buf_push = result_valid_i && result_ready_o;
	assign buf_pop = (buf_cnt_reg != 2'h0);
	assign buf_latch = buf_pop && !hs_active;
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			buf_cnt_reg <= 2'h0;
			buf_wr_ptr_reg <= 1'b0;
			buf_rd_ptr_reg <= 1'b0;
		end
		else
		begin
			if (buf_push)
				buf_wr_ptr_reg <= !buf_wr_ptr_reg;
			if (buf_pop)
				buf_rd_ptr_reg <= !buf_rd_ptr_reg;
			buf_cnt_reg <= buf_cnt_reg + {1'b0, buf_push} - {1'b0, buf_pop};
		end
	end
	always_ff @(posedge clk_i)
	begin
		if (buf_push)
			buf_reg[buf_wr_ptr_reg] <= result_i;
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			out_reg <= '0;
			status_reg <= 1'b1;
		end
		else if (buf_latch)
		begin
			out_reg <= buf_reg[buf_rd_ptr_reg];
			status_reg <= 1'b0;
		end
		else if (result_valid_i)
			status_reg <= 1'b1;
	end
	assign port.status = status_reg;
	assign busy_o = hs_active;

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			mode_prev_reg <= 1'b0;
			hs_req_reg <= 1'b0;
		end
		else
		begin
			mode_prev_reg <= mode_sync_reg[1];
			if ((mode_sync_reg[1] && !mode_prev_reg) || (buf_latch && mode_sync_reg[1]))
				hs_req_reg <= 1'b1;
			else if (state_reg == adc_port_pkg::HS_WAIT_HI)
				hs_req_reg <= 1'b0;
		end
	end

	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			send_smp_reg <= 1'b0;
		else if (fall_tick)
			send_smp_reg <= send_sync_reg[1];
	end

	// Handshake sequencer
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			state_reg <= adc_port_pkg::HS_IDLE;
			load_n_reg <= 1'b1;
			hbe_reg <= 1'b1;
			lbe_reg <= 1'b1;
			hold_cnt_reg <= 2'h0;
		end
		else
		begin
			case (state_reg)
				adc_port_pkg::HS_IDLE:
					if (hs_req_reg)
						state_reg <= adc_port_pkg::HS_WAIT_HI;
				adc_port_pkg::HS_WAIT_HI:
					if (rise_tick && send_smp_reg)
					begin
						load_n_reg <= 1'b0;
						hbe_reg <= 1'b0;
						state_reg <= adc_port_pkg::HS_HI_LOAD;
					end
				adc_port_pkg::HS_HI_LOAD, adc_port_pkg::HS_LO_LOAD:
					if (rise_tick)
					begin
						load_n_reg <= 1'b1;
						state_reg <= (state_reg == adc_port_pkg::HS_HI_LOAD) ?
							adc_port_pkg::HS_HI_HOLD : adc_port_pkg::HS_LO_HOLD;
					end
				adc_port_pkg::HS_HI_HOLD, adc_port_pkg::HS_LO_HOLD:
					if (fall_tick && send_sync_reg[1] && hold_cnt_reg == 2'h0)
						hold_cnt_reg <= 2'h1;
					else if (rise_tick && hold_cnt_reg == 2'h1)
					begin
						hold_cnt_reg <= 2'h0;
						if (state_reg == adc_port_pkg::HS_HI_HOLD)
						begin
							hbe_reg <= 1'b1;
							lbe_reg <= 1'b0;
							load_n_reg <= 1'b0;
							state_reg <= adc_port_pkg::HS_LO_LOAD;
						end
						else
						begin
							lbe_reg <= 1'b1;
							state_reg <= adc_port_pkg::HS_DONE;
						end
					end
				adc_port_pkg::HS_DONE:
					state_reg <= adc_port_pkg::HS_IDLE;
				default:
					state_reg <= adc_port_pkg::HS_IDLE;
			endcase
		end
	end

	// drive pins in handshake mode or while a handshake sequence is still active
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
			hs_oe_reg <= 1'b0;
		else
			hs_oe_reg <= mode_sync_reg[1] || hs_active;
	end
	assign port.load_n_dev = load_n_reg;
	assign port.load_n_dev_oe = hs_oe_reg;
	assign port.high_byte_enable_dev = hbe_reg;
	assign port.low_byte_enable_dev = lbe_reg;
	assign port.byte_en_dev_oe = hs_oe_reg;

	// Data drivers for both modes
	always_ff @(posedge clk_i)
	begin
		if (reset_i)
		begin
			data_reg <= 8'h00;
			oe_reg <= 8'h00;
		end
		else if (hs_oe_reg)
		begin
			// byte layout; data off at falling edge
			if (!hbe_reg && !(state_reg == adc_port_pkg::HS_HI_HOLD && hold_cnt_reg == 2'h1))
			begin
				data_reg <= high_byte(out_reg);
				oe_reg <= 8'h3F;
			end
			else if (!lbe_reg && !(state_reg == adc_port_pkg::HS_LO_HOLD && hold_cnt_reg == 2'h1))
			begin
				data_reg <= out_reg[7:0];
				oe_reg <= 8'hFF;
			end
			else
				oe_reg <= 8'h00;
		end
		else if (!ce_sync_reg[1] && lbe_sync_reg[1])
		begin
			data_reg <= out_reg[7:0];
			oe_reg <= 8'hFF;
		end
		else if (!ce_sync_reg[1] && hbe_sync_reg[1])
		begin
			data_reg <= high_byte(out_reg);
			oe_reg <= 8'h3F;
		end
		else
			oe_reg <= 8'h00;
	end
	assign port.data = data_reg;
	assign port.data_oe = oe_reg;
endmodule
`default_nettype wire

// file: bench/adc_port_chk.sv
// Pin checker between converter and receiver ends
`default_nettype none
module adc_port_chk (
	input wire logic clk_i,
	input wire logic reset_i,
	input wire logic [7:0] data_oe,
	input wire logic load_n_dev,
	input wire logic load_n_dev_oe,
	input wire logic high_byte_enable_dev,
	input wire logic low_byte_enable_dev,
	input wire logic byte_en_dev_oe,
	input wire logic load_n_rx,
	input wire logic high_byte_enable_rx,
	input wire logic low_byte_enable_rx,
	input wire logic send,
	input wire logic mode,
	input wire logic status
);
	timeunit 1ns;
	timeprecision 1ps;
	default clocking @(posedge clk_i); endclocking
	default disable iff (reset_i);
	sequence load_low_s;
		!load_n_dev [*8] ##1 load_n_dev;
	endsequence
	sequence flag_low_s;
		!high_byte_enable_dev [*8] ##1 !high_byte_enable_dev [*8];
	endsequence
	load_width_a: assert property ($fell(load_n_dev) && load_n_dev_oe |-> load_low_s)
		else $error("load low not one period");
	flag_width_a: assert property ($fell(high_byte_enable_dev) && byte_en_dev_oe |-> flag_low_s)
		else $error("high flag short");
	load_start_a: assert property ($fell(load_n_dev) && load_n_dev_oe |->
		$fell(high_byte_enable_dev) || $fell(low_byte_enable_dev))
		else $error("load without byte flag");
	high_first_a: assert property ($fell(low_byte_enable_dev) && byte_en_dev_oe |-> $rose(high_byte_enable_dev))
		else $error("low byte not after high");
	stall_hold_a: assert property (!send [*8] ##0 (!low_byte_enable_dev && byte_en_dev_oe) |=> !low_byte_enable_dev)
		else $error("flag dropped while stalled");
	hi_group_a: assert property (byte_en_dev_oe && !high_byte_enable_dev && data_oe != 8'h00 |-> data_oe == 8'h3F)
		else $error("high group width");
	lo_group_a: assert property (byte_en_dev_oe && !low_byte_enable_dev && data_oe != 8'h00 |-> data_oe == 8'hFF)
		else $error("low group width");
	pins_input_a: assert property (!mode [*4] |-> !load_n_dev_oe && !byte_en_dev_oe)
		else $error("pins driven in direct mode");
	direct_gate_a: assert property (!mode [*4] ##0 (data_oe != 8'h00) |->
		!$past(load_n_rx, 3) && ($past(high_byte_enable_rx, 3) || $past(low_byte_enable_rx, 3)))
		else $error("data driven without enables");
	idle_latch_a: assert property ($fell(status) && $past(byte_en_dev_oe) |->
		$past(high_byte_enable_dev) && $past(low_byte_enable_dev))
		else $error("result latched mid sequence");
	ready_direct_a: assert property (!mode |-> send)
		else $error("ready low in direct mode");
	stall_data_a: assert property (!send [*8] ##0 (data_oe != 8'h00 && byte_en_dev_oe) |=>
		$stable(data_oe))
		else $error("data dropped while stalled");
endmodule
`default_nettype wire

// file: bench/adc_port_tb_top.sv
// Bench joining converter and receiver ends
`default_nettype none
module adc_port_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic clk_i = 0;
	logic reset_i = 1;
	logic [13:0] result_i = 14'h0000;
	logic [13:0] r;
	logic result_valid_i = 0, mode_i = 0, run_i = 0, read_high_i = 0, read_low_i = 0, out_ready_i = 0, stall = 0;
	logic result_ready_o, convert_o, busy_o, byte_high_o, byte_valid_o, new_data_o;
	logic [7:0] byte_o;
	logic [31:0] seed = 32'h00000056;
	logic [8:0] exp_q[$];
	int error_cnt = 0;
	int n_compared = 0;
	adc_port_if u_adc_port_if();
	adc_port_dev u_adc_port_dev (.clk_i(clk_i), .reset_i(reset_i), .port(u_adc_port_if), .result_i(result_i),
		.result_valid_i(result_valid_i), .result_ready_o(result_ready_o), .convert_o(convert_o), .busy_o(busy_o));
	adc_port_rx u_adc_port_rx (.clk_i(clk_i), .reset_i(reset_i), .port(u_adc_port_if), .mode_i(mode_i),
		.run_i(run_i), .read_high_i(read_high_i), .read_low_i(read_low_i), .out_ready_i(out_ready_i),
		.byte_o(byte_o), .byte_high_o(byte_high_o), .byte_valid_o(byte_valid_o), .new_data_o(new_data_o));
	adc_port_chk u_adc_port_chk (.clk_i(clk_i), .reset_i(reset_i), .data_oe(u_adc_port_if.data_oe),
		.load_n_dev(u_adc_port_if.load_n_dev), .load_n_dev_oe(u_adc_port_if.load_n_dev_oe),
		.high_byte_enable_dev(u_adc_port_if.high_byte_enable_dev),
		.low_byte_enable_dev(u_adc_port_if.low_byte_enable_dev), .byte_en_dev_oe(u_adc_port_if.byte_en_dev_oe),
		.load_n_rx(u_adc_port_if.load_n_rx), .high_byte_enable_rx(u_adc_port_if.high_byte_enable_rx),
		.low_byte_enable_rx(u_adc_port_if.low_byte_enable_rx), .send(u_adc_port_if.send),
		.mode(u_adc_port_if.mode), .status(u_adc_port_if.status));
	initial
	begin
		forever #2.5 clk_i = ~clk_i;
	end
	function automatic logic [31:0] rnd();
		seed = seed ^ (seed << 13);
		seed = seed ^ (seed >> 17);
		seed = seed ^ (seed << 5);
		return seed;
	endfunction
	task automatic cmp(input string name, input logic [15:0] e, input logic [15:0] g);
		n_compared++;
		if (g !== e)
		begin
			error_cnt++;
			$display("unexpected %s expected %h seen %h", name, e, g);
		end
	endtask
	task automatic final_report();
		if (error_cnt == 0 && n_compared > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask
	task automatic wait_for(input int k);
		for (int i = 0; i <= 3000; i++)
		begin
			if (i == 3000)
			begin
				cmp("wait", 16'h0001, 16'h0000);
				final_report();
			end
			@(posedge clk_i);
			if (k == 0 ? new_data_o === 1'b1 : k == 1 ? busy_o === 1'b0 : exp_q.size() == 0)
				break;
		end
	endtask
	task automatic send_res(input logic [13:0] v, input bit pair);
		if (pair)
		begin
			exp_q.push_back({3'h4, v[13:8]});
			exp_q.push_back({1'b0, v[7:0]});
		end
		@(negedge clk_i);
		result_i <= v;
		result_valid_i <= 1'b1;
		for (int i = 0; i <= 60; i++)
		begin
			@(posedge clk_i);
			if (result_ready_o === 1'b1 || i == 60)
				break;
		end
		cmp("result taken", 16'h0001, {15'h0000, result_ready_o});
		@(negedge clk_i);
		result_valid_i <= 1'b0;
	endtask
	always @(negedge clk_i)
		out_ready_i <= !stall && rnd() % 2;
	// Byte stream sink with expectation queue
	always @(posedge clk_i)
		if (!reset_i && mode_i && byte_valid_o === 1'b1 && out_ready_i)
			cmp("byte", exp_q.size() != 0 ? {7'h00, exp_q.pop_front()} : 16'hFFFF, {7'h00, byte_high_o, byte_o});
	initial
	begin
		repeat (20) @(negedge clk_i);
		reset_i <= 1'b0;
		run_i <= 1'b1;
		repeat (2) @(negedge clk_i);
		@(posedge clk_i);
		r = 14'(rnd());
		send_res(r, 0);
		wait_for(0);
		cmp("convert", 16'h0001, {15'h0000, convert_o});
		run_i <= 1'b0;
		repeat (4) @(negedge clk_i);
		cmp("hold", 16'h0000, {15'h0000, convert_o});
		run_i <= 1'b1;
		for (int k = 1; k <= 3; k++)
		begin
			@(negedge clk_i);
			read_high_i <= k[0];
			read_low_i <= k[1];
			repeat (6) @(negedge clk_i);
			cmp("oe", k == 1 ? 16'h003F : 16'h00FF, {8'h00, u_adc_port_if.data_oe});
			cmp("data", k == 1 ? {10'h000, r[13:8]} : {8'h00, r[7:0]},
				{8'h00, u_adc_port_if.data & u_adc_port_if.data_oe});
			read_high_i <= 1'b0;
			read_low_i <= 1'b0;
			repeat (6) @(negedge clk_i);
			cmp("released", 16'h0000, {8'h00, u_adc_port_if.data_oe});
		end
		exp_q.push_back({3'h4, r[13:8]});
		exp_q.push_back({1'b0, r[7:0]});
		mode_i <= 1'b1;
		wait_for(2);
		wait_for(1);
		for (int n = 0; n < 4; n++)
		begin
			r = 14'(rnd());
			stall = n == 3;
			send_res(r, 1);
			if (stall)
			begin
				repeat (20) @(negedge clk_i);
				send_res(14'(rnd()), 0);
				repeat (130) @(negedge clk_i);
			end
			stall = 0;
			wait_for(2);
			wait_for(1);
		end
		repeat (100) @(negedge clk_i);
		cmp("drained", 16'h0000, {15'h0000, byte_valid_o});
		mode_i <= 1'b0;
		repeat (10) @(negedge clk_i);
		exp_q.push_back({3'h4, r[13:8]});
		exp_q.push_back({1'b0, r[7:0]});
		mode_i <= 1'b1;
		wait_for(2);
		wait_for(1);
		final_report();
	end
endmodule
`default_nettype wire
